// File: src/cwg_top.sv
// compare and waveform generation section of a control timer unit
// assumes the counter core on aclk supplies value, direction, top/zero and update strobes
//
// How it works
// - channels are compare-only after reset
// - counter compared against every compare value continuously
// - buffers move to active at update or command 3
// - match flag set on the count tick
// - match gives irq, event if enabled; DMA always
// - mode field selects seven waveform configurations
// - TOP from channel 0 in match frequency mode
// - update at zero in dual-slope, else wrap
// - normal frequency toggles output on each match
// - match frequency toggles channel zero on update
// - single-slope up: set at TOP, clear at match
// - single-slope down: clear at zero, set at match
// - period TOP+1 ticks, prescaled upstream
// - dual-slope: set on up match, clear down
// - both-ends mode also updates at TOP
// - dual-slope except critical: compare MSB selects ramp when TOP below half
// - critical mode uses channel x+2 when down
// - overflow flag placement follows the mode
// - polarity one swaps single-slope set and clear
// - per-channel inversion after waveform generation
// - polarity one swaps dual-slope set and clear
// - polarity gives frequency modes their initial level
// - count tick merges prescaler and event ticks
`timescale 1ns/100ps
module cwg_top
  import cwg_pkg::*;
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address and data
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [CWG_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // axi4-lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic      [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [CWG_ADDR_W-1:0]  s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  // counter core
  input  wire logic [CWG_CNT_W-1:0]   counter_value,
  input  wire logic                   count_down,
  input  wire logic                   prescale_tick,
  input  wire logic                   event_tick,
  input  wire logic                   counter_at_top,
  input  wire logic                   counter_at_zero,
  input  wire logic                   counter_update,
  output logic      [CWG_CNT_W-1:0]   top_value_r,
  output logic                        unit_enable_r,
  // waveform pins and match consumers
  output logic      [CWG_CH_N-1:0]    waveform_output_r,
  output logic      [CWG_CH_N-1:0]    match_irq_r,
  output logic      [CWG_CH_N-1:0]    match_event_r,
  output logic      [CWG_CH_N-1:0]    match_dma_req_r,
  output logic                        overflow_event_r
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic cwg_class_t mode_class(input logic [2:0] m);
    case (m)
      CWG_MODE_NORMAL_FREQUENCY_MODE, CWG_MODE_MATCH_FREQUENCY_MODE: mode_class = CWG_CLS_FREQ;
      CWG_MODE_SINGLE_SLOPE_PWM_MODE:                mode_class = CWG_CLS_SS;
      CWG_MODE_DSCR:                mode_class = CWG_CLS_CRIT;
      CWG_MODE_DSBO, CWG_MODE_DSBT, CWG_MODE_DSTP: mode_class = CWG_CLS_DS;
      default:                      mode_class = CWG_CLS_FREQ;
    endcase
  endfunction

  function automatic logic is_cmpb(input logic [CWG_ADDR_W-1:0] a);
    is_cmpb = (a[7:4] == CWG_OFS_CMPB0[7:4]) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [2:0]             mode_r;
  logic [CWG_CH_N-1:0]    polarity_r;
  logic [CWG_CH_N-1:0]    invert_r;
  logic [CWG_CH_N-1:0]    irq_en_r;
  logic [CWG_CH_N-1:0]    evt_en_r;
  logic [CWG_CH_N-1:0]    match_flag_r;
  logic                   overflow_flag_r;
  logic [CWG_CNT_W-1:0]   period_r;
  logic [CWG_CNT_W-1:0]   cmp_r [CWG_CH_N];
  logic [CWG_BUF_N-1:0]   buf_valid_r;
  logic [CWG_CH_N-1:0]    wave_r;
  cwg_class_t             cls;

  assign cls = mode_class(mode_r);

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic                   aw_got_r;
  logic                   w_got_r;
  logic [CWG_ADDR_W-1:0]  wr_addr_r;
  logic [31:0]            wr_data_r;
  logic                   wr_full_r;
  logic                   rd_pend_r;
  logic [CWG_ADDR_W-1:0]  rd_addr_r;
  logic                   do_write;
  logic                   wr_ok;
  logic                   force_update;
  logic [CWG_CNT_W-1:0]   mem_rdata;
  logic [CWG_BUF_N*CWG_CNT_W-1:0] buf_words;
  logic                   mem_we;
  logic [2:0]             mem_waddr;
  logic [CWG_CH_N-1:0]    flag_clr;

  assign do_write  = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok     = do_write && wr_full_r;
  // partial-strobe writes are answered but change nothing
  assign mem_we    = wr_ok && (is_cmpb(wr_addr_r) || (wr_addr_r == CWG_OFS_PERBUF));
  assign mem_waddr = is_cmpb(wr_addr_r) ? {1'b0, wr_addr_r[3:2]} : 3'(CWG_PER_SLOT);
  assign force_update = wr_ok && (wr_addr_r == CWG_OFS_CTRL) &&
                        (wr_data_r[CWG_CTRL_CMD_LSB +: 2] == CWG_CMD_UPDATE);
  assign flag_clr  = (wr_ok && wr_addr_r == CWG_OFS_FLAGS) ? wr_data_r[CWG_CH_N-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      wr_addr_r     <= '0;
      wr_data_r     <= '0;
      wr_full_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CWG_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r   <= 1'b1;
        wr_data_r <= s_axi_wdata;
        wr_full_r <= (s_axi_wstrb == 4'hF);
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_r > CWG_OFS_BUFV || wr_addr_r[1:0] != 2'h0) ? CWG_RESP_SLVERR : CWG_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  cwg_buf_mem u_buf (
    .aclk      (aclk),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (wr_data_r[CWG_CNT_W-1:0]),
    .rd_addr   (is_cmpb(s_axi_araddr) ? {1'b0, s_axi_araddr[3:2]} : 3'(CWG_PER_SLOT)),
    .rd_data   (mem_rdata),
    .all_words (buf_words)
  );

  // read: address taken, then one cycle for the buffer memory, then rvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_r     <= 1'b0;
      rd_addr_r     <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= CWG_RESP_OKAY;
    end else begin
      s_axi_arready <= !rd_pend_r && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_r <= 1'b1;
        rd_addr_r <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= CWG_RESP_OKAY;
        s_axi_rdata  <= '0;
        if (is_cmpb(rd_addr_r) || rd_addr_r == CWG_OFS_PERBUF) begin
          s_axi_rdata <= {8'h00, mem_rdata};
        end else if (rd_addr_r[7:4] == CWG_OFS_CMP0[7:4] && rd_addr_r[1:0] == 2'h0) begin
          s_axi_rdata <= {8'h00, cmp_r[rd_addr_r[3:2]]};
        end else begin
          case (rd_addr_r)
            CWG_OFS_CTRL:   s_axi_rdata <= {31'h0, unit_enable_r};
            CWG_OFS_WAVE:   s_axi_rdata <= {20'h0, polarity_r, 5'h0, mode_r};
            CWG_OFS_DRV:    s_axi_rdata <= {28'h0, invert_r};
            CWG_OFS_INTEN:  s_axi_rdata <= {28'h0, irq_en_r};
            CWG_OFS_EVEN:   s_axi_rdata <= {28'h0, evt_en_r};
            CWG_OFS_FLAGS:  s_axi_rdata <= {23'h0, overflow_flag_r, 4'h0, match_flag_r};
            CWG_OFS_PERIOD: s_axi_rdata <= {8'h00, period_r};
            CWG_OFS_TOP:    s_axi_rdata <= {8'h00, top_value_r};
            CWG_OFS_BUFV:   s_axi_rdata <= {27'h0, buf_valid_r};
            default:        s_axi_rresp <= CWG_RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_enable_r <= 1'b0;
      mode_r        <= CWG_RST_MODE;
      polarity_r    <= '0;
      invert_r      <= '0;
      irq_en_r      <= '0;
      evt_en_r      <= '0;
    end else if (wr_ok) begin
      case (wr_addr_r)
        CWG_OFS_CTRL:  unit_enable_r <= wr_data_r[CWG_CTRL_EN_BIT];
        CWG_OFS_WAVE: begin
          mode_r     <= wr_data_r[2:0];
          polarity_r <= wr_data_r[CWG_WAVE_POL_LSB +: CWG_CH_N];
        end
        CWG_OFS_DRV:   invert_r <= wr_data_r[CWG_CH_N-1:0];
        CWG_OFS_INTEN: irq_en_r <= wr_data_r[CWG_CH_N-1:0];
        CWG_OFS_EVEN:  evt_en_r <= wr_data_r[CWG_CH_N-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // double buffering
  // ----------------------------------------------------------------
  logic tick;
  logic update_now;

  assign tick = prescale_tick | event_tick;
  assign update_now = force_update ||
                      (unit_enable_r && tick &&
                       ((cls == CWG_CLS_DS || cls == CWG_CLS_CRIT) ?
                        (counter_at_zero || (mode_r == CWG_MODE_DSBT && counter_at_top)) :
                        counter_update));

  // a buffer write in the update cycle keeps its valid bit for the next update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_valid_r <= '0;
      period_r    <= CWG_RST_PERIOD;
      for (int c = 0; c < CWG_CH_N; c++) begin
        cmp_r[c] <= CWG_RST_CMP;
      end
    end else begin
      for (int k = 0; k < CWG_BUF_N; k++) begin
        if (mem_we && mem_waddr == 3'(k)) begin
          buf_valid_r[k] <= 1'b1;
        end else if (update_now && buf_valid_r[k]) begin
          buf_valid_r[k] <= 1'b0;
        end
      end
      if (update_now) begin
        for (int c = 0; c < CWG_CH_N; c++) begin
          if (buf_valid_r[c]) begin
            cmp_r[c] <= buf_words[c*CWG_CNT_W +: CWG_CNT_W];
          end
        end
        if (buf_valid_r[CWG_PER_SLOT]) begin
          period_r <= buf_words[CWG_PER_SLOT*CWG_CNT_W +: CWG_CNT_W];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_value_r <= CWG_RST_PERIOD;
    end else begin
      top_value_r <= (mode_r == CWG_MODE_MATCH_FREQUENCY_MODE) ? cmp_r[0] : period_r;
    end
  end

  // ----------------------------------------------------------------
  // compare channels
  // ----------------------------------------------------------------
  logic [CWG_CH_N-1:0] hit;
  logic                ramp_sel;

  // compare mode is the only mode, so no capture path can engage
  assign ramp_sel = (cls == CWG_CLS_DS) && (top_value_r < CWG_HALF_MAX);

  genvar i;
  generate
    for (i = 0; i < CWG_CH_N; i++) begin : g_ch
      logic [CWG_CNT_W-1:0] ref_v;
      logic [CWG_CNT_W-1:0] cmp_v;
      logic                 dir_ok;
      logic                 set_e;
      logic                 clr_e;

      assign ref_v  = (cls == CWG_CLS_CRIT && count_down) ?
                      cmp_r[(i + CWG_HALF_N) % CWG_CH_N] : cmp_r[i];
      assign cmp_v  = ramp_sel ? {1'b0, ref_v[CWG_CNT_W-2:0]} : ref_v;
      assign dir_ok = !ramp_sel || (ref_v[CWG_CNT_W-1] == count_down);
      assign hit[i] = unit_enable_r && tick && dir_ok && (counter_value == cmp_v);

      // clears win over sets on the same tick, so a compare equal to TOP/ZERO gives a flat output
      always_comb begin
        set_e = 1'b0;
        clr_e = 1'b0;
        if (cls == CWG_CLS_SS) begin
          if (!count_down) begin
            set_e = counter_at_top;
            clr_e = hit[i];
          end else begin
            clr_e = counter_at_zero;
            set_e = hit[i];
          end
        end else begin
          set_e = hit[i] && !count_down;
          clr_e = hit[i] && count_down;
        end
        if (polarity_r[i]) begin
          {set_e, clr_e} = {clr_e, set_e};
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          wave_r[i] <= 1'b0;
        end else if (!unit_enable_r) begin
          wave_r[i] <= polarity_r[i];
        end else if (cls == CWG_CLS_FREQ) begin
          if (i == 0 && mode_r == CWG_MODE_MATCH_FREQUENCY_MODE) begin
            wave_r[i] <= wave_r[i] ^ (tick && counter_update);
          end else begin
            wave_r[i] <= wave_r[i] ^ hit[i];
          end
        end else if (tick) begin
          if (clr_e) begin
            wave_r[i] <= 1'b0;
          end else if (set_e) begin
            wave_r[i] <= 1'b1;
          end
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          match_flag_r[i]      <= 1'b0;
          match_irq_r[i]       <= 1'b0;
          match_event_r[i]     <= 1'b0;
          match_dma_req_r[i]   <= 1'b0;
          waveform_output_r[i] <= 1'b0;
        end else begin
          match_flag_r[i]      <= hit[i] | (match_flag_r[i] & ~flag_clr[i]);
          match_irq_r[i]       <= hit[i] & irq_en_r[i];
          match_event_r[i]     <= hit[i] & evt_en_r[i];
          match_dma_req_r[i]   <= hit[i];
          waveform_output_r[i] <= wave_r[i] ^ invert_r[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // overflow
  // ----------------------------------------------------------------
  logic ovf_hit;

  always_comb begin
    ovf_hit = 1'b0;
    case (mode_r)
      CWG_MODE_NORMAL_FREQUENCY_MODE, CWG_MODE_MATCH_FREQUENCY_MODE, CWG_MODE_SINGLE_SLOPE_PWM_MODE:
        ovf_hit = count_down ? counter_at_zero : counter_at_top;
      CWG_MODE_DSCR, CWG_MODE_DSBO: ovf_hit = counter_at_zero && count_down;
      CWG_MODE_DSBT: ovf_hit = (counter_at_top && !count_down) || (counter_at_zero && count_down);
      CWG_MODE_DSTP: ovf_hit = counter_at_top && !count_down;
      default:       ovf_hit = 1'b0;
    endcase
    ovf_hit = ovf_hit && tick && unit_enable_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_r  <= 1'b0;
      overflow_event_r <= 1'b0;
    end else begin
      overflow_flag_r  <= ovf_hit | (overflow_flag_r &
                          ~(wr_ok && wr_addr_r == CWG_OFS_FLAGS && wr_data_r[CWG_FLAG_OVF_BIT]));
      overflow_event_r <= ovf_hit;
    end
  end
endmodule // cwg_top

// File: src/cwg_pkg.sv
// constants shared by the compare waveform generator and its buffer memory
// assumes a 24-bit counter core with four compare channels on the same clock
package cwg_pkg;
  localparam int unsigned CWG_CNT_W  = 24;
  localparam int unsigned CWG_CH_N   = 4;
  localparam int unsigned CWG_HALF_N = 2;
  localparam int unsigned CWG_ADDR_W = 8;
  localparam int unsigned CWG_BUF_N  = 5;
  localparam int unsigned CWG_PER_SLOT = 4;

  localparam logic [CWG_CNT_W-1:0] CWG_HALF_MAX = 24'h800000;

  // register byte offsets
  localparam logic [7:0] CWG_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CWG_OFS_WAVE    = 8'h04;
  localparam logic [7:0] CWG_OFS_DRV     = 8'h08;
  localparam logic [7:0] CWG_OFS_INTEN   = 8'h0C;
  localparam logic [7:0] CWG_OFS_EVEN    = 8'h10;
  localparam logic [7:0] CWG_OFS_FLAGS   = 8'h14;
  localparam logic [7:0] CWG_OFS_PERIOD  = 8'h18;
  localparam logic [7:0] CWG_OFS_PERBUF  = 8'h1C;
  localparam logic [7:0] CWG_OFS_CMP0    = 8'h20;
  localparam logic [7:0] CWG_OFS_CMPB0   = 8'h30;
  localparam logic [7:0] CWG_OFS_TOP     = 8'h40;
  localparam logic [7:0] CWG_OFS_BUFV    = 8'h44;

  // field positions
  localparam int unsigned CWG_CTRL_EN_BIT  = 0;
  localparam int unsigned CWG_CTRL_CMD_LSB = 4;
  localparam int unsigned CWG_WAVE_POL_LSB = 8;
  localparam int unsigned CWG_FLAG_OVF_BIT = 8;
  localparam logic [1:0]  CWG_CMD_UPDATE   = 2'h3;

  // reset values
  localparam logic [CWG_CNT_W-1:0] CWG_RST_PERIOD = 24'hFFFFFF;
  localparam logic [CWG_CNT_W-1:0] CWG_RST_CMP    = 24'h000000;
  localparam logic [2:0]           CWG_RST_MODE   = 3'h0;

  localparam logic [1:0] CWG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CWG_RESP_SLVERR = 2'h2;

  // waveform_mode_select encodings
  localparam logic [2:0] CWG_MODE_NORMAL_FREQUENCY_MODE = 3'h0;
  localparam logic [2:0] CWG_MODE_MATCH_FREQUENCY_MODE = 3'h1;
  localparam logic [2:0] CWG_MODE_SINGLE_SLOPE_PWM_MODE = 3'h2;
  localparam logic [2:0] CWG_MODE_DSCR = 3'h4;
  localparam logic [2:0] CWG_MODE_DSBO = 3'h5;
  localparam logic [2:0] CWG_MODE_DSBT = 3'h6;
  localparam logic [2:0] CWG_MODE_DSTP = 3'h7;

  // one-hot decoded waveform class
  typedef enum logic [3:0] {
    CWG_CLS_FREQ = 4'b0001,
    CWG_CLS_SS   = 4'b0010,
    CWG_CLS_DS   = 4'b0100,
    CWG_CLS_CRIT = 4'b1000
  } cwg_class_t;
endpackage

// File: src/cwg_buf_mem.sv
// small word memory holding the compare and period buffers
// one write port, one registered read port, all words also visible in parallel
`timescale 1ns/100ps
module cwg_buf_mem
  import cwg_pkg::*;
(
  // clock
  input  wire logic                              aclk,
  // write port
  input  wire logic                              wr_en,
  input  wire logic [2:0]                        wr_addr,
  input  wire logic [CWG_CNT_W-1:0]              wr_data,
  // read port
  input  wire logic [2:0]                        rd_addr,
  output logic      [CWG_CNT_W-1:0]              rd_data,
  // parallel view, word k at bits k*W
  output logic      [CWG_BUF_N*CWG_CNT_W-1:0]    all_words
);
  logic [CWG_CNT_W-1:0] mem_r [CWG_BUF_N];

  always_ff @(posedge aclk) begin
    if (wr_en && (wr_addr < 3'(CWG_BUF_N))) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    rd_data <= (rd_addr < 3'(CWG_BUF_N)) ? mem_r[rd_addr] : '0;
  end

  genvar k;
  generate
    for (k = 0; k < CWG_BUF_N; k++) begin : g_flat
      assign all_words[k*CWG_CNT_W +: CWG_CNT_W] = mem_r[k];
    end
  endgenerate
endmodule // cwg_buf_mem

// File: verif/cwg_chk_asserts.sv
// checker for cwg_top: bus answer timing and the causes of match and overflow pulses
// sees only top-level ports; bound onto every cwg_top instance
`timescale 1ns/100ps
module cwg_chk
  import cwg_pkg::*;
(
  // clock, reset and bus handshakes
  input wire logic                aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // counter core and match consumers
  input wire logic                prescale_tick, event_tick, counter_at_top, counter_at_zero,
  input wire logic                unit_enable_r, overflow_event_r,
  input wire logic [CWG_CH_N-1:0] match_irq_r, match_event_r, match_dma_req_r
);
  logic tick_w;
  assign tick_w = prescale_tick | event_tick;
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  quiet_when_off_a: assert property ((match_dma_req_r != '0 || overflow_event_r) |-> $past(unit_enable_r))
    else $error("pulse while unit disabled");
  dma_always_a: assert property (((match_irq_r | match_event_r) & ~match_dma_req_r) == '0)
    else $error("irq or event without dma request");
  pulse_tick_a: assert property (match_dma_req_r != '0 |-> $past(tick_w))
    else $error("match pulse without count tick");
  ovf_cause_a: assert property (overflow_event_r |-> $past(tick_w && (counter_at_top || counter_at_zero)))
    else $error("overflow pulse without top or zero");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not two cycles after address");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  cover property (match_dma_req_r[0] && match_irq_r[0]);
  cover property (overflow_event_r);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // cwg_chk
bind cwg_top cwg_chk i_chk (.*);

// File: verif/cwg_core_model.sv
// counter core stand-in: single-slope up count or dual-slope ramps on every clock
// assumes top comes back from the design's top_value_r on the same clock
`timescale 1ns/100ps
module cwg_core_model
  import cwg_pkg::*;
(
  // clock and control
  input  wire logic                 aclk, aresetn, run, dual,
  input  wire logic [CWG_CNT_W-1:0] top,
  // counter outputs
  output logic      [CWG_CNT_W-1:0] counter_value,
  output logic                      count_down, prescale_tick, event_tick,
  output logic                      counter_at_top, counter_at_zero, counter_update
);
  logic [CWG_CNT_W-1:0] cnt_r;
  logic                 down_r;
  logic                 phase_r;
  // ticks alternate between the two sources so that both reach the merged count
  assign prescale_tick = run & ~phase_r;
  assign event_tick = run & phase_r;
  assign counter_value = cnt_r;
  assign count_down = down_r;
  assign counter_at_top = cnt_r == top;
  assign counter_at_zero = cnt_r == '0;
  assign counter_update = dual ? counter_at_zero : counter_at_top;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cnt_r, down_r, phase_r} <= '0;
    end else if (run) begin
      phase_r <= ~phase_r;
      // >= so a shrinking top wraps at once instead of running to the 24-bit limit
      if (!dual) begin
        {down_r, cnt_r} <= {1'b0, (cnt_r >= top) ? '0 : cnt_r + 1'b1};
      end else if (!down_r && cnt_r >= top) begin
        {down_r, cnt_r} <= {1'b1, cnt_r - 1'b1};
      end else if (down_r && cnt_r == '0) begin
        {down_r, cnt_r} <= {1'b0, cnt_r + 1'b1};
      end else begin
        cnt_r <= down_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
      end
    end
  end
endmodule // cwg_core_model

// File: verif/tb.sv
// self-checking bench for cwg_top: axi4-lite register access and waveform measurement
// assumes cwg_core_model drives the counter inputs and cwg_chk is bound to the design
`timescale 1ns/100ps
module tb;
  import cwg_pkg::*;
  logic aclk = 0, aresetn = 0, run = 0, dual = 0, w0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, unit_enable_r, overflow_event_r;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [CWG_CNT_W-1:0] counter_value, top_value_r;
  logic count_down, prescale_tick, event_tick, counter_at_top, counter_at_zero, counter_update;
  logic [CWG_CH_N-1:0] waveform_output_r, match_irq_r, match_event_r, match_dma_req_r;
  int fails = 0, compares = 0, cyc = 0, hi, ed, dm, iq, ev, ov;
  // wave, invert, dual, enable, cycles, high, edges, dma, overflow; 99 leaves a count unchecked
  int tc [10][9] = '{'{2, 0, 0, 1, 20, 8, 4, 2, 2},
    '{258, 0, 0, 1, 20, 12, 4, 2, 2},
    '{2, 1, 0, 1, 20, 12, 4, 2, 2},
    '{0, 0, 0, 1, 20, 10, 2, 2, 2},
    '{4, 0, 1, 1, 36, 14, 4, 4, 2},
    '{6, 0, 1, 1, 36, 36, 0, 2, 4},
    '{7, 0, 1, 1, 36, 36, 0, 2, 2},
    '{1, 0, 0, 1, 20, 99, 5, 5, 5},
    '{261, 0, 1, 1, 36, 0, 0, 2, 2},
    '{256, 0, 0, 0, 20, 20, 0, 0, 0}};
  cwg_core_model i_core (.aclk(aclk), .aresetn(aresetn), .run(run), .dual(dual), .top(top_value_r),
    .counter_value(counter_value), .count_down(count_down), .prescale_tick(prescale_tick), .event_tick(event_tick),
    .counter_at_top(counter_at_top), .counter_at_zero(counter_at_zero), .counter_update(counter_update));
  cwg_top i_dut (.*);
  initial forever #20 aclk = ~aclk;
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    if (exp !== 32'd99) begin
      compares++;
      if (got !== exp) begin
        fails++;
        $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    {aw_done, w_done} = 2'b00;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'b111, a, v};
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done |= s_axi_awready;
      w_done |= s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {!aw_done, !w_done};
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {v, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    {aresetn, run} <= 2'b11;
    repeat (2) @(posedge aclk);
    chk(waveform_output_r, 4'h0);
    rd(CWG_OFS_TOP, d, r);
    chk(d, CWG_RST_PERIOD);
    rd(8'h48, d, r);
    chk(d, 32'h0);
    chk(r, CWG_RESP_SLVERR);
    wr(CWG_OFS_PERBUF, 32'h9);
    wr(CWG_OFS_CMPB0, 32'h3);
    wr(CWG_OFS_CMPB0 + 8'h8, 32'h8);
    rd(CWG_OFS_PERIOD, d, r);
    chk(d, CWG_RST_PERIOD);
    wr(CWG_OFS_CTRL, 32'h30);
    rd(CWG_OFS_PERIOD, d, r);
    chk(d, 32'h9);
    wr(CWG_OFS_INTEN, 32'hF);
    wr(CWG_OFS_EVEN, 32'hF);
    for (int k = 0; k < 10; k++) begin
      wr(CWG_OFS_WAVE, tc[k][0]);
      wr(CWG_OFS_DRV, tc[k][1]);
      wr(CWG_OFS_CTRL, tc[k][3]);
      dual <= tc[k][2] != 0;
      repeat (40) @(posedge aclk);
      {hi, ed, dm, iq, ev, ov} = '0;
      w0 = waveform_output_r[0];
      repeat (tc[k][4]) begin
        @(posedge aclk);
        hi += waveform_output_r[0];
        ed += waveform_output_r[0] !== w0;
        w0 = waveform_output_r[0];
        dm += match_dma_req_r[0];
        iq += match_irq_r[0];
        ev += match_event_r[0];
        ov += overflow_event_r;
      end
      chk(hi, tc[k][5]);
      chk(ed, tc[k][6]);
      chk(dm, tc[k][7]);
      chk(ov, tc[k][8]);
      chk(iq, dm);
      chk(ev, dm);
      chk(unit_enable_r, tc[k][3]);
      if (tc[k][0] == 1) rd(CWG_OFS_TOP, d, r);
      if (tc[k][0] == 1) chk(d, 32'h3);
    end
    rd(CWG_OFS_FLAGS, d, r);
    chk(d & 32'h101, 32'h101);
    wr(CWG_OFS_FLAGS, 32'h101);
    rd(CWG_OFS_FLAGS, d, r);
    chk(d & 32'h101, 32'h0);
    wr(CWG_OFS_WAVE, 32'h2);
    wr(CWG_OFS_CTRL, 32'h1);
    wr(CWG_OFS_CMPB0, 32'h5);
    repeat (25) @(posedge aclk);
    rd(CWG_OFS_CMP0, d, r);
    chk(d, 32'h5);
    complete_run();
  end
endmodule // tb
